/* rtl/ddt_regs.sv */
// Debug trigger, accumulator and breakpoint trap register bank
// How it works
// - Each trigger has a 32-bit read/write compare address
// - PC compares force address bit 0 to zero
// - Eight sticky trigger flags in accumulator low byte
// - Accumulator read returns flags then clears; writes ignored
// - Monitor start address bits 31:1 start trap code
// - Monitor address resets from constant, field, core index
// - Context save pointer bits 31:6 hold save address
// - Context pointer resets from constant, field, core index
// - Taking a breakpoint trap sets trap-active flag
// - Return-from-monitor clears the trap-active flag
// - Core register writes set or clear trap-active
// - Trap-active flag is one after reset
// - Traps taken only while trap-active is zero
`timescale 1ns/1ps
module ddt_regs #(
  parameter int NUM_TRIG = ddt_pkg::NUM_TRIG
) (
  // Clock and reset
  input  wire logic                  I_CLK_SYS,
  input  wire logic                  I_RST_N,
  // Core register access (move to / from core register)
  input  wire logic                  I_WR,
  input  wire logic                  I_RD,
  input  wire logic [15:0]           I_ADDR,
  input  wire logic [31:0]           I_WDATA,
  output logic      [31:0]           O_RDATA,
  output logic                       O_RVALID,
  // Pipeline events
  input  wire logic                  I_TRAP_REQ,
  input  wire logic                  I_RETURN_FROM_MONITOR,
  output logic                       O_TRAP_TAKEN,
  output logic                       O_TRAP_ACTIVE,
  output logic      [31:0]           O_MONITOR_PC,
  output logic      [31:0]           O_CTX_SAVE_ADDR,
  // Trigger comparators
  input  wire logic [NUM_TRIG-1:0]   I_TRIG_HIT,
  input  wire logic [NUM_TRIG-1:0]   I_TRIG_PC_MODE,
  output logic      [NUM_TRIG*32-1:0] O_CMP_ADDR,
  // Strap
  input  wire logic [1:0]            I_CORE_INDEX
);

  logic [NUM_TRIG-1:0]    sel_trig;
  logic [NUM_TRIG-1:0]    seen;
  logic [NUM_TRIG*32-1:0] trig_addr;
  logic [31:0]            trig_rd;
  logic                   sel_tcr;
  logic                   sel_acc;
  logic                   sel_mon;
  logic                   sel_ctx;
  logic                   acc_rd;
  logic                   tcr_wr;
  logic                   trap_take;
  logic [31:0]            rd_mux;
  logic [31:0]            acc_view;
  logic [31:0]            mon_rst;
  logic [31:0]            ctx_rst;
  logic                   load_now;

  logic        trap_active_r;
  logic        trap_active_nxt;
  logic        taken_r;
  logic [31:0] mon_r;
  logic [31:0] mon_nxt;
  logic [31:0] ctx_r;
  logic [31:0] ctx_nxt;
  logic [31:0] rdata_r;
  logic        rvalid_r;
  logic [1:0]  core_s1_r;
  logic [1:0]  core_s2_r;
  logic [1:0]  init_cnt_r;
  logic [1:0]  init_cnt_nxt;
  logic        init_done_r;

  // Address decode
  assign sel_tcr  = (I_ADDR == ddt_pkg::OFS_TRAP_CONTROL);
  assign sel_acc  = (I_ADDR == ddt_pkg::OFS_TRIG_ACCUM);
  assign sel_mon  = (I_ADDR == ddt_pkg::OFS_MONITOR_START);
  assign sel_ctx  = (I_ADDR == ddt_pkg::OFS_CONTEXT_SAVE);
  assign acc_rd   = I_RD & sel_acc;
  assign tcr_wr   = I_WR & sel_tcr;

  // Trigger slots
  genvar k;
  generate
    for (k = 0; k < NUM_TRIG; k++) begin : g_trig
      localparam logic [15:0] SLOT_OFS =
        16'(ddt_pkg::OFS_TRIG_ADDR_BASE + 16'(k) * ddt_pkg::TRIG_ADDR_STRIDE);
      assign sel_trig[k] = (I_ADDR == SLOT_OFS);
      ddt_trig_slot u_slot (
        .i_clk      (I_CLK_SYS),
        .i_rst_n    (I_RST_N),
        .i_wr_en    (I_WR & sel_trig[k]),
        .i_wdata    (I_WDATA),
        .i_acc_rd   (acc_rd),
        .i_hit      (I_TRIG_HIT[k]),
        .i_pc_mode  (I_TRIG_PC_MODE[k]),
        .o_addr     (trig_addr[k*32 +: 32]),
        .o_cmp_addr (O_CMP_ADDR[k*32 +: 32]),
        .o_seen     (seen[k])
      );
    end
  endgenerate

  always_comb begin
    trig_rd = 32'h0;
    for (int i = 0; i < NUM_TRIG; i++) begin
      trig_rd = trig_rd | (sel_trig[i] ? trig_addr[i*32 +: 32] : 32'h0);
    end
  end

  // Reserved accumulator bits read zero
  assign acc_view = 32'(seen[ddt_pkg::ACC_FLAGS_W-1:0]);

  // Unmapped addresses read zero
  assign rd_mux = sel_tcr ? {31'h0, trap_active_r} :
                  sel_acc ? acc_view :
                  sel_mon ? mon_r :
                  sel_ctx ? ctx_r : trig_rd;

  // Core index strap: synchronised, then loaded once after reset
  assign mon_rst = {ddt_pkg::RST_UPPER, ddt_pkg::RST_MON_FIELD, core_s2_r,
                    ddt_pkg::RST_MON_LOW};
  assign ctx_rst = {ddt_pkg::RST_UPPER, ddt_pkg::RST_CTX_FIELD, core_s2_r,
                    ddt_pkg::RST_CTX_LOW};
  assign load_now     = ~init_done_r & (init_cnt_r == ddt_pkg::STRAP_SYNC_CYCLES);
  assign init_cnt_nxt = init_done_r ? init_cnt_r : 2'(init_cnt_r + 2'h1);

  // Strap load beats a software write that races it
  assign mon_nxt = load_now ? mon_rst :
                   (I_WR & sel_mon) ? (I_WDATA & ddt_pkg::MON_WR_MASK) : mon_r;
  assign ctx_nxt = load_now ? ctx_rst :
                   (I_WR & sel_ctx) ? (I_WDATA & ddt_pkg::CTX_WR_MASK) : ctx_r;

  // Trap gate and trap-active flag; the trap's set wins over any clear
  assign trap_take       = I_TRAP_REQ & ~trap_active_r;
  assign trap_active_nxt = trap_take             ? 1'b1 :
                           tcr_wr                ? I_WDATA[ddt_pkg::TCR_ACTIVE_BIT] :
                           I_RETURN_FROM_MONITOR ? 1'b0 :
                           trap_active_r;

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      trap_active_r <= ddt_pkg::RST_TRAP_ACTIVE;
      taken_r       <= 1'b0;
    end else begin
      trap_active_r <= trap_active_nxt;
      taken_r       <= trap_take;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      mon_r <= 32'h0;
      ctx_r <= 32'h0;
    end else begin
      mon_r <= mon_nxt;
      ctx_r <= ctx_nxt;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      core_s1_r   <= 2'h0;
      core_s2_r   <= 2'h0;
      init_cnt_r  <= 2'h0;
      init_done_r <= 1'b0;
    end else begin
      core_s1_r   <= I_CORE_INDEX;
      core_s2_r   <= core_s1_r;
      init_cnt_r  <= init_cnt_nxt;
      init_done_r <= init_done_r | load_now;
    end
  end

  // Read answer one cycle after the strobe; data holds until the next read
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rdata_r  <= 32'h0;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r  <= I_RD ? rd_mux : rdata_r;
      rvalid_r <= I_RD;
    end
  end

  assign O_RDATA         = rdata_r;
  assign O_RVALID        = rvalid_r;
  assign O_TRAP_TAKEN    = taken_r;
  assign O_TRAP_ACTIVE   = trap_active_r;
  assign O_MONITOR_PC    = mon_r;
  assign O_CTX_SAVE_ADDR = ctx_r;

  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_N);

  // Trap gate checks
  AST_TRAP_TAKE_SETS: assert property (
    (I_TRAP_REQ && !trap_active_r) |=> O_TRAP_TAKEN && trap_active_r
  ) else $error("trap taken without setting trap-active");

  AST_TRAP_BLOCKED: assert property (
    trap_active_r |=> !O_TRAP_TAKEN
  ) else $error("trap taken while trap-active set");

  AST_TAKEN_CAUSE: assert property (
    O_TRAP_TAKEN |-> $past(I_TRAP_REQ) && !$past(O_TRAP_ACTIVE)
  ) else $error("trap taken without a gated request");

  AST_TAKEN_PULSE: assert property (
    O_TRAP_TAKEN |=> !O_TRAP_TAKEN
  ) else $error("second trap taken back to back");

  AST_ACTIVE_HOLDS: assert property (
    (!I_TRAP_REQ && !tcr_wr && !I_RETURN_FROM_MONITOR) |=> $stable(O_TRAP_ACTIVE)
  ) else $error("trap-active changed with no cause");

  AST_RETURN_CLEARS: assert property (
    (I_RETURN_FROM_MONITOR && !trap_take && !tcr_wr) |=> !O_TRAP_ACTIVE
  ) else $error("return from monitor left trap-active set");

  AST_TRAP_CTRL_WRITE: assert property (
    (tcr_wr && !trap_take) |=> O_TRAP_ACTIVE == $past(I_WDATA[0])
  ) else $error("trap control write not applied");

  AST_TRAP_CTRL_READ: assert property (
    (I_RD && sel_tcr) |=> O_RDATA == {31'h0, $past(O_TRAP_ACTIVE)}
  ) else $error("trap control read data wrong");

  // Read side, accumulator, start address, context pointer, strap load and trap-active reset value checks
  AST_RVALID_SET: assert property (
    I_RD |=> O_RVALID
  ) else $error("read answer missing");

  AST_RVALID_PULSE: assert property (
    !I_RD |=> !O_RVALID
  ) else $error("read answer without a read");

  AST_RDATA_HOLD: assert property (
    !I_RD |=> $stable(O_RDATA)
  ) else $error("read data changed without a read");

  AST_ACC_SETS: assert property (
    (I_TRIG_HIT != '0) |=> (seen & $past(I_TRIG_HIT)) == $past(I_TRIG_HIT)
  ) else $error("trigger hit not recorded");

  AST_ACC_READ: assert property (
    acc_rd |=> O_RVALID && O_RDATA == {24'h0, $past(seen)}
  ) else $error("accumulator read data wrong");

  AST_ACC_CLEAR: assert property (
    (acc_rd && I_TRIG_HIT == '0) |=> seen == '0
  ) else $error("accumulator not cleared by read");

  AST_ACC_WR_IGNORED: assert property (
    (I_WR && sel_acc && !acc_rd) |=> seen == ($past(seen) | $past(I_TRIG_HIT))
  ) else $error("accumulator changed by write");

  AST_ACC_HIT_KEPT: assert property (
    acc_rd |=> (seen & $past(I_TRIG_HIT)) == $past(I_TRIG_HIT)
  ) else $error("hit lost during accumulator read");

  AST_MON_WRITE: assert property (
    (I_WR && sel_mon && init_done_r) |=> O_MONITOR_PC == ($past(I_WDATA) & 32'hffff_fffe)
  ) else $error("monitor start address write wrong");

  AST_MON_RESERVED: assert property (
    O_MONITOR_PC[0] == 1'b0
  ) else $error("monitor start address bit 0 not zero");

  AST_MON_READ: assert property (
    (I_RD && sel_mon) |=> O_RDATA == $past(O_MONITOR_PC)
  ) else $error("monitor start address read wrong");

  AST_CTX_WRITE: assert property (
    (I_WR && sel_ctx && init_done_r) |=> O_CTX_SAVE_ADDR == ($past(I_WDATA) & 32'hffff_ffc0)
  ) else $error("context pointer write wrong");

  AST_CTX_RESERVED: assert property (
    O_CTX_SAVE_ADDR[5:0] == 6'h00
  ) else $error("context pointer low bits not zero");

  AST_CTX_READ: assert property (
    (I_RD && sel_ctx) |=> O_RDATA == $past(O_CTX_SAVE_ADDR)
  ) else $error("context pointer read wrong");

  AST_STRAP_LOAD: assert property (
    load_now |=> O_MONITOR_PC[31:12] == 20'ha0000 && O_MONITOR_PC[7:6] == $past(core_s2_r)
                 && O_CTX_SAVE_ADDR[8:7] == $past(core_s2_r)
  ) else $error("reset address not loaded from core index");

  AST_ACTIVE_AFTER_RESET: assert property (
    (!init_done_r && init_cnt_r == 2'h0) |-> trap_active_r
  ) else $error("trap-active not one after reset");

  COV_TRAP: cover property (I_TRAP_REQ && !trap_active_r ##[1:8] I_RETURN_FROM_MONITOR);
  COV_ACC_READ: cover property (acc_rd && seen != '0);
  COV_HIT_ON_READ: cover property (acc_rd && I_TRIG_HIT != '0);
  COV_BLOCKED: cover property (I_TRAP_REQ && trap_active_r);

endmodule : ddt_regs

/* rtl/ddt_pkg.sv */
// Constants shared by the debug trigger and trap register bank
package ddt_pkg;

  // Core register port
  localparam int          ADDR_W             = 16;
  localparam int          DATA_W             = 32;
  localparam int          NUM_TRIG           = 8;
  localparam int          CORE_IDX_W         = 2;

  // Register offsets
  localparam logic [15:0] OFS_TRAP_CONTROL   = 16'hfd48;
  localparam logic [15:0] OFS_TRIG_ACCUM     = 16'hfd30;
  localparam logic [15:0] OFS_MONITOR_START  = 16'hfd40;
  localparam logic [15:0] OFS_CONTEXT_SAVE   = 16'hfd44;
  localparam logic [15:0] OFS_TRIG_ADDR_BASE = 16'hf000;
  localparam logic [15:0] TRIG_ADDR_STRIDE   = 16'h0004;

  // Field positions
  localparam int          TCR_ACTIVE_BIT     = 0;
  localparam int          ACC_FLAGS_W        = 8;

  // Values after reset
  localparam logic [31:0] RST_TRIG_ADDR      = 32'h0000_0000;
  localparam logic        RST_TRAP_ACTIVE    = 1'h1;
  localparam logic [19:0] RST_UPPER          = 20'ha0000;
  localparam logic [3:0]  RST_MON_FIELD      = 4'h1;
  localparam logic [5:0]  RST_MON_LOW        = 6'h00;
  localparam logic [2:0]  RST_CTX_FIELD      = 3'h2;
  localparam logic [6:0]  RST_CTX_LOW        = 7'h00;

  // Writable bits
  localparam logic [31:0] MON_WR_MASK        = 32'hffff_fffe;
  localparam logic [31:0] CTX_WR_MASK        = 32'hffff_ffc0;
  localparam logic [31:0] PC_CMP_MASK        = 32'hffff_fffe;

  // Cycles from reset release until the core index is loaded
  localparam logic [1:0]  STRAP_SYNC_CYCLES  = 2'h2;

endpackage : ddt_pkg

/* rtl/ddt_trig_slot.sv */
// One debug trigger: compare address register and sticky seen flag
`timescale 1ns/1ps
module ddt_trig_slot (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // Register access
  input  wire logic        i_wr_en,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_acc_rd,
  // Trigger side
  input  wire logic        i_hit,
  input  wire logic        i_pc_mode,
  output logic      [31:0] o_addr,
  output logic      [31:0] o_cmp_addr,
  output logic             o_seen
);

  logic [31:0] addr_r;
  logic [31:0] addr_nxt;
  logic [31:0] cmp_r;
  logic [31:0] cmp_nxt;
  logic        seen_r;
  logic        seen_nxt;

  assign addr_nxt = i_wr_en ? i_wdata : addr_r;
  // PC fetches are halfword aligned, so bit 0 never takes part
  assign cmp_nxt  = i_pc_mode ? (addr_nxt & ddt_pkg::PC_CMP_MASK) : addr_nxt;
  // Set wins over the read clear so a hit in the read cycle survives
  assign seen_nxt = i_hit | (seen_r & ~i_acc_rd);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      addr_r <= ddt_pkg::RST_TRIG_ADDR;
      cmp_r  <= ddt_pkg::RST_TRIG_ADDR;
      seen_r <= 1'h0;
    end else begin
      addr_r <= addr_nxt;
      cmp_r  <= cmp_nxt;
      seen_r <= seen_nxt;
    end
  end

  assign o_addr     = addr_r;
  assign o_cmp_addr = cmp_r;
  assign o_seen     = seen_r;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  AST_SLOT_WRITE: assert property (
    i_wr_en |=> addr_r == $past(i_wdata)
  ) else $error("trigger address not stored");

  AST_SLOT_PCMASK: assert property (
    i_pc_mode |=> (cmp_r[0] == 1'b0) && (cmp_r[31:1] == addr_r[31:1])
  ) else $error("pc compare address bit 0 not zero");

  AST_SLOT_HIT_KEPT: assert property (
    (i_hit && i_acc_rd) |=> seen_r ##1 (seen_r || $past(i_acc_rd))
  ) else $error("hit lost during accumulator read");

endmodule : ddt_trig_slot

/* tb/ddt_core_model.sv */
// Core pipeline and trigger comparator model facing the register bank
`timescale 1ns/1ps
module ddt_core_model (
  // Clock
  input  wire logic       i_clk,
  // Pipeline events
  output logic            o_trap_req,
  output logic            o_return_from_monitor,
  output logic      [7:0] o_trig_hit
);
  initial begin
    o_trap_req            = 1'b0;
    o_return_from_monitor = 1'b0;
    o_trig_hit            = 8'h00;
  end

  // One request cycle; the bank decides whether it is taken
  task automatic trap_request();
    @(posedge i_clk);
    o_trap_req <= 1'b1;
    @(posedge i_clk);
    o_trap_req <= 1'b0;
    #1;
  endtask : trap_request

  task automatic leave_monitor();
    @(posedge i_clk);
    o_return_from_monitor <= 1'b1;
    @(posedge i_clk);
    o_return_from_monitor <= 1'b0;
    #1;
  endtask : leave_monitor

  task automatic fire(input logic [7:0] hits);
    @(posedge i_clk);
    o_trig_hit <= hits;
    @(posedge i_clk);
    o_trig_hit <= 8'h00;
    #1;
  endtask : fire
endmodule : ddt_core_model

/* tb/test_ddt_regs.sv */
// Self-checking bench for the debug trigger and trap register bank
`timescale 1ns/1ps
module test_ddt_regs;
  logic         clk;
  logic         rst_n;
  logic         wr;
  logic         rd;
  logic [15:0]  addr;
  logic [31:0]  wdata;
  logic [31:0]  rdata;
  logic         rvalid;
  logic         trap_req;
  logic         leave_mon;
  logic [1:0]   core_idx;
  logic         taken;
  logic         active;
  logic [31:0]  mon_pc;
  logic [31:0]  ctx_addr;
  logic [7:0]   hit;
  logic [7:0]   pc_mode;
  logic [255:0] cmp_addr;
  logic [31:0]  got;
  logic [31:0]  val;
  int           bad_count;
  int           num_checks;

  ddt_regs u_ddt_regs (
    .I_CLK_SYS             (clk),
    .I_RST_N               (rst_n),
    .I_WR                  (wr),
    .I_RD                  (rd),
    .I_ADDR                (addr),
    .I_WDATA               (wdata),
    .O_RDATA               (rdata),
    .O_RVALID              (rvalid),
    .I_TRAP_REQ            (trap_req),
    .I_RETURN_FROM_MONITOR (leave_mon),
    .O_TRAP_TAKEN          (taken),
    .O_TRAP_ACTIVE         (active),
    .O_MONITOR_PC          (mon_pc),
    .O_CTX_SAVE_ADDR       (ctx_addr),
    .I_TRIG_HIT            (hit),
    .I_TRIG_PC_MODE        (pc_mode),
    .O_CMP_ADDR            (cmp_addr),
    .I_CORE_INDEX          (core_idx)
  );

  ddt_core_model u_ddt_core_model (
    .i_clk                 (clk),
    .o_trap_req            (trap_req),
    .o_return_from_monitor (leave_mon),
    .o_trig_hit            (hit)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t ns: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg

  // Data sampled just after the answer edge, where it has settled
  task automatic rd_reg(input logic [15:0] a, output logic [31:0] d);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
    check({31'h0, rvalid}, 32'h1);
  endtask : rd_reg

  task automatic final_report();
    if (bad_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    repeat (3000) @(posedge clk);
    bad_count++;
    final_report();
  end

  initial begin
    rst_n      = 1'b0;
    wr         = 1'b0;
    rd         = 1'b0;
    addr       = 16'h0000;
    wdata      = 32'h0000_0000;
    pc_mode    = 8'h00;
    core_idx   = 2'h2;
    bad_count  = 0;
    num_checks = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd_reg(16'hfd48, got);
    check(got, 32'h1);
    check(mon_pc, {20'ha0000, 4'h1, 2'h2, 6'h00});
    check(ctx_addr, {20'ha0000, 3'h2, 2'h2, 7'h00});
    rd_reg(16'hfd30, got);
    check(got, 32'h0);
    u_ddt_core_model.trap_request();
    check({31'h0, taken}, 32'h0);
    wr_reg(16'hfd48, 32'h0);
    check({31'h0, active}, 32'h0);
    u_ddt_core_model.trap_request();
    check({31'h0, taken}, 32'h1);
    check({31'h0, active}, 32'h1);
    u_ddt_core_model.trap_request();
    check({31'h0, taken}, 32'h0);
    u_ddt_core_model.leave_monitor();
    check({31'h0, active}, 32'h0);
    wr_reg(16'hfd48, 32'h1);
    check({31'h0, active}, 32'h1);
    // Low half compares against the PC, upper half keeps bit 0
    @(posedge clk);
    pc_mode <= 8'h0f;
    for (int k = 0; k < 8; k++) begin
      val = 32'h1357_9bdf + 32'(k * 256);
      wr_reg(16'hf000 + 16'(4 * k), val);
      rd_reg(16'hf000 + 16'(4 * k), got);
      check(got, val);
      check(cmp_addr[32*k +: 32], (k < 4) ? (val & 32'hffff_fffe) : val);
    end
    u_ddt_core_model.fire(8'ha5);
    rd_reg(16'hfd30, got);
    check(got, 32'ha5);
    u_ddt_core_model.fire(8'h5a);
    wr_reg(16'hfd30, 32'hffff_ffff);
    rd_reg(16'hfd30, got);
    check(got, 32'h5a);
    rd_reg(16'hfd30, got);
    check(got, 32'h0);
    u_ddt_core_model.fire(8'h81);
    fork
      rd_reg(16'hfd30, got);
      u_ddt_core_model.fire(8'h42);
    join
    check(got, 32'h81);
    rd_reg(16'hfd30, got);
    check(got, 32'h42);
    wr_reg(16'hfd40, 32'h8765_4321);
    rd_reg(16'hfd40, got);
    check(got, 32'h8765_4320);
    check(mon_pc, 32'h8765_4320);
    wr_reg(16'hfd44, 32'h89ab_cdef);
    rd_reg(16'hfd44, got);
    check(got, 32'h89ab_cdc0);
    check(ctx_addr, 32'h89ab_cdc0);
    rd_reg(16'hfd4c, got);
    check(got, 32'h0);
    // Second application reset, strapped as another core
    @(posedge clk);
    rst_n    <= 1'b0;
    core_idx <= 2'h1;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd_reg(16'hfd48, got);
    check(got, 32'h1);
    rd_reg(16'hf000, got);
    check(got, 32'h0);
    check(mon_pc, {20'ha0000, 4'h1, 2'h1, 6'h00});
    check(ctx_addr, {20'ha0000, 3'h2, 2'h1, 7'h00});
    final_report();
  end
endmodule : test_ddt_regs
